// ### hw/irig_out_defines.vh
`ifndef IRIG_OUT_DEFINES_VH
`define IRIG_OUT_DEFINES_VH

// Register byte addresses
`define ADDR_OUT_ENABLE      16'h6060
`define ADDR_DELAY_ADJUST    16'h6068
`define ADDR_LEAP_TIME       16'h606C
`define ADDR_SECONDS         16'h6080
`define ADDR_MINUTES         16'h6084
`define ADDR_HOURS           16'h6088
`define ADDR_DAYS            16'h608C
`define ADDR_YEARS           16'h6090
`define ADDR_CONTROL_FIELD   16'h6094
`define ADDR_BINARY_SECONDS  16'h6098
`define ADDR_WIDTH           16

// Writable field masks, reserved bits read as zero
`define MASK_OUT_ENABLE      32'h0000_0001
`define MASK_DELAY_ADJUST    32'h0000_FFFF
`define MASK_LEAP_TIME       32'h7F01_FF1F
`define MASK_SECONDS         32'h0000_007F
`define MASK_MINUTES         32'h0000_007F
`define MASK_HOURS           32'h0000_003F
`define MASK_DAYS            32'h0000_03FF
`define MASK_YEARS           32'h0000_00FF
`define MASK_CONTROL_FIELD   32'h0003_FFFF
`define MASK_BINARY_SECONDS  32'h0001_FFFF

// Leap second time field positions
`define LEAP_YEAR_HI         30
`define LEAP_YEAR_LO         24
`define LEAP_DAY_HI          16
`define LEAP_DAY_LO          8
`define LEAP_HOUR_HI         4
`define LEAP_HOUR_LO         0

// Register reset value
`define REG_RESET            32'h0000_0000

// AXI responses
`define RESP_OKAY            2'b00
`define RESP_SLVERR          2'b10

// Timing: one output frame per second at 200 MHz
`define CLK_PERIOD_NS        5
`define FRAME_PERIOD_NS      1000000000
`define FRAME_CYCLES         (`FRAME_PERIOD_NS / `CLK_PERIOD_NS)

`endif

// ### hw/irig_output_time_registers.v
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
`include "irig_out_defines.vh"

module irig_output_time_registers #(
  parameter [31:0] P_FRAME_CYCLES = `FRAME_CYCLES
) (
  // Clock and reset
  input wire i_sys_clk,
  input wire i_nrst,
  // AXI4-Lite write address
  input wire [15:0] i_s_axi_awaddr,
  input wire i_s_axi_awvalid,
  output wire o_s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] i_s_axi_wdata,
  input wire [3:0] i_s_axi_wstrb,
  input wire i_s_axi_wvalid,
  output wire o_s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] o_s_axi_bresp,
  output reg o_s_axi_bvalid,
  input wire i_s_axi_bready,
  // AXI4-Lite read address
  input wire [15:0] i_s_axi_araddr,
  input wire i_s_axi_arvalid,
  output wire o_s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] o_s_axi_rdata,
  output reg [1:0] o_s_axi_rresp,
  output reg o_s_axi_rvalid,
  input wire i_s_axi_rready,
  // Frame data toward the time code encoder
  output reg o_frame_start,
  output reg [6:0] o_frame_seconds,
  output reg [6:0] o_frame_minutes,
  output reg [5:0] o_frame_hours,
  output reg [9:0] o_frame_days,
  output reg [7:0] o_frame_years,
  output reg [17:0] o_frame_control,
  output reg [16:0] o_frame_straight_binary_seconds_of_day,
  output reg o_frame_leap_insert
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Byte lane merge, masked to the implemented bits
  function [31:0] lane_merge;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0] strb;
    input [31:0] mask;
    integer k;
    begin
      lane_merge = old_val;
      for (k = 0; k < 4; k = k + 1) begin
        if (strb[k]) begin
          lane_merge[k*8 +: 8] = new_val[k*8 +: 8];
        end
      end
      lane_merge = lane_merge & mask;
    end
  endfunction

  // Register map decode shared by both channels so they cannot disagree
  function addr_mapped;
    input [15:0] addr;
    begin
      case (addr)
        `ADDR_OUT_ENABLE, `ADDR_DELAY_ADJUST, `ADDR_LEAP_TIME: addr_mapped = 1'b1;
        `ADDR_SECONDS, `ADDR_MINUTES, `ADDR_HOURS, `ADDR_DAYS: addr_mapped = 1'b1;
        `ADDR_YEARS, `ADDR_CONTROL_FIELD, `ADDR_BINARY_SECONDS: addr_mapped = 1'b1;
        default: addr_mapped = 1'b0;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register storage

  reg [31:0] out_enable_reg;
  reg [31:0] delay_adjust_reg;
  reg [31:0] leap_time_reg;
  reg [31:0] seconds_reg;
  reg [31:0] minutes_reg;
  reg [31:0] hours_reg;
  reg [31:0] days_reg;
  reg [31:0] years_reg;
  reg [31:0] control_field_reg;
  reg [31:0] binary_seconds_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Write channel: address and data held independently, either order

  reg aw_held_reg;
  reg w_held_reg;
  reg [15:0] aw_addr_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;
  wire do_write;
  wire addr_hit;
  wire enable_toggle;
  wire [31:0] enable_next;

  // Accept each channel only once per write, and not while a response waits
  assign o_s_axi_awready = ~aw_held_reg & ~o_s_axi_bvalid;
  assign o_s_axi_wready = ~w_held_reg & ~o_s_axi_bvalid;
  assign do_write = aw_held_reg & w_held_reg & ~o_s_axi_bvalid;

  // Unmapped words store nothing and answer with an error
  assign addr_hit = addr_mapped(aw_addr_reg);

  // A write that changes the enable bit in either direction is a toggle
  // Rewriting the same value is no toggle, so a refresh keeps the settings
  assign enable_next = lane_merge(out_enable_reg, w_data_reg, w_strb_reg, `MASK_OUT_ENABLE);
  assign enable_toggle = do_write && (aw_addr_reg == `ADDR_OUT_ENABLE) &&
    (enable_next != out_enable_reg);

  // Channel capture and response
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= 16'h0000;
      w_data_reg <= `REG_RESET;
      w_strb_reg <= 4'h0;
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp <= `RESP_OKAY;
    end else begin
      if (i_s_axi_awvalid && o_s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= {i_s_axi_awaddr[15:2], 2'b00};
      end
      if (i_s_axi_wvalid && o_s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= i_s_axi_wdata;
        w_strb_reg <= i_s_axi_wstrb;
      end
      if (do_write) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        o_s_axi_bvalid <= 1'b1;
        o_s_axi_bresp <= addr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (o_s_axi_bvalid && i_s_axi_bready) begin
        o_s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Register updates; a toggle of the enable wipes every setting
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      out_enable_reg <= `REG_RESET;
      delay_adjust_reg <= `REG_RESET;
      leap_time_reg <= `REG_RESET;
      seconds_reg <= `REG_RESET;
      minutes_reg <= `REG_RESET;
      hours_reg <= `REG_RESET;
      days_reg <= `REG_RESET;
      years_reg <= `REG_RESET;
      control_field_reg <= `REG_RESET;
      binary_seconds_reg <= `REG_RESET;
    end else if (enable_toggle) begin
      out_enable_reg <= enable_next;
      delay_adjust_reg <= `REG_RESET;
      leap_time_reg <= `REG_RESET;
      seconds_reg <= `REG_RESET;
      minutes_reg <= `REG_RESET;
      hours_reg <= `REG_RESET;
      days_reg <= `REG_RESET;
      years_reg <= `REG_RESET;
      control_field_reg <= `REG_RESET;
      binary_seconds_reg <= `REG_RESET;
    end else if (do_write) begin
      case (aw_addr_reg)
        `ADDR_DELAY_ADJUST: begin
          delay_adjust_reg <= lane_merge(delay_adjust_reg, w_data_reg, w_strb_reg,
            `MASK_DELAY_ADJUST);
        end
        `ADDR_LEAP_TIME: begin
          // Year, day and hour fields in one word
          leap_time_reg <= lane_merge(leap_time_reg, w_data_reg, w_strb_reg,
            `MASK_LEAP_TIME);
        end
        `ADDR_SECONDS: begin
          seconds_reg <= lane_merge(seconds_reg, w_data_reg, w_strb_reg, `MASK_SECONDS);
        end
        `ADDR_MINUTES: begin
          minutes_reg <= lane_merge(minutes_reg, w_data_reg, w_strb_reg, `MASK_MINUTES);
        end
        `ADDR_HOURS: begin
          hours_reg <= lane_merge(hours_reg, w_data_reg, w_strb_reg, `MASK_HOURS);
        end
        `ADDR_DAYS: begin
          days_reg <= lane_merge(days_reg, w_data_reg, w_strb_reg, `MASK_DAYS);
        end
        `ADDR_YEARS: begin
          years_reg <= lane_merge(years_reg, w_data_reg, w_strb_reg, `MASK_YEARS);
        end
        `ADDR_CONTROL_FIELD: begin
          control_field_reg <= lane_merge(control_field_reg, w_data_reg, w_strb_reg,
            `MASK_CONTROL_FIELD);
        end
        `ADDR_BINARY_SECONDS: begin
          binary_seconds_reg <= lane_merge(binary_seconds_reg, w_data_reg, w_strb_reg,
            `MASK_BINARY_SECONDS);
        end
        default: begin
          out_enable_reg <= out_enable_reg;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel: one cycle to data, held until taken

  reg [31:0] rd_mux;
  reg rd_hit;
  wire [15:0] rd_addr;

  assign o_s_axi_arready = ~o_s_axi_rvalid;
  // Word aligned read address, low byte lanes ignored
  assign rd_addr = {i_s_axi_araddr[15:2], 2'b00};

  // Read decode; reserved bits already zero in storage
  always @* begin
    rd_mux = `REG_RESET;
    rd_hit = addr_mapped(rd_addr);
    case (rd_addr)
      `ADDR_OUT_ENABLE: rd_mux = out_enable_reg;
      `ADDR_DELAY_ADJUST: rd_mux = delay_adjust_reg;
      `ADDR_LEAP_TIME: rd_mux = leap_time_reg;
      `ADDR_SECONDS: rd_mux = seconds_reg;
      `ADDR_MINUTES: rd_mux = minutes_reg;
      `ADDR_HOURS: rd_mux = hours_reg;
      `ADDR_DAYS: rd_mux = days_reg;
      `ADDR_YEARS: rd_mux = years_reg;
      `ADDR_CONTROL_FIELD: rd_mux = control_field_reg;
      `ADDR_BINARY_SECONDS: rd_mux = binary_seconds_reg;
      default: rd_mux = `REG_RESET;
    endcase
  end

  // Read response
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata <= `REG_RESET;
      o_s_axi_rresp <= `RESP_OKAY;
    end else if (i_s_axi_arvalid && o_s_axi_arready) begin
      o_s_axi_rvalid <= 1'b1;
      o_s_axi_rdata <= rd_mux;
      o_s_axi_rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (o_s_axi_rvalid && i_s_axi_rready) begin
      o_s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame timing

  reg [31:0] sec_count_reg;
  wire [31:0] sec_last;
  wire [31:0] adjust_cycles;
  wire [31:0] start_point;
  wire leap_match;

  assign sec_last = P_FRAME_CYCLES - 32'h0000_0001;
  // Adjust counts clock cycles; clamp so the start stays inside the second
  // Limitation: a large jump of the adjust mid second can bring two markers close
  assign adjust_cycles = (delay_adjust_reg > sec_last) ? sec_last : delay_adjust_reg;
  // Start earlier than the boundary by the adjust value
  assign start_point = sec_last - adjust_cycles;

  // Free running second base, restarted on any enable toggle
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sec_count_reg <= 32'h0000_0000;
    end else if (enable_toggle || sec_count_reg == sec_last) begin
      sec_count_reg <= 32'h0000_0000;
    end else begin
      sec_count_reg <= sec_count_reg + 32'h0000_0001;
    end
  end

  // Leap second due when the frame time reaches the scheduled hour
  assign leap_match =
    (years_reg[`LEAP_YEAR_HI-`LEAP_YEAR_LO:0] ==
      leap_time_reg[`LEAP_YEAR_HI:`LEAP_YEAR_LO]) &&
    (days_reg[`LEAP_DAY_HI-`LEAP_DAY_LO:0] ==
      leap_time_reg[`LEAP_DAY_HI:`LEAP_DAY_LO]) &&
    (hours_reg[`LEAP_HOUR_HI-`LEAP_HOUR_LO:0] ==
      leap_time_reg[`LEAP_HOUR_HI:`LEAP_HOUR_LO]);

  // Frame data snapshot at the shifted start so fields cannot tear mid frame
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_frame_start <= 1'b0;
      o_frame_seconds <= 7'h00;
      o_frame_minutes <= 7'h00;
      o_frame_hours <= 6'h00;
      o_frame_days <= 10'h000;
      o_frame_years <= 8'h00;
      o_frame_control <= 18'h00000;
      o_frame_straight_binary_seconds_of_day <= 17'h00000;
      o_frame_leap_insert <= 1'b0;
    end else if (enable_toggle) begin
      o_frame_start <= 1'b0;
      o_frame_seconds <= 7'h00;
      o_frame_minutes <= 7'h00;
      o_frame_hours <= 6'h00;
      o_frame_days <= 10'h000;
      o_frame_years <= 8'h00;
      o_frame_control <= 18'h00000;
      o_frame_straight_binary_seconds_of_day <= 17'h00000;
      o_frame_leap_insert <= 1'b0;
    end else if (out_enable_reg[0] && sec_count_reg == start_point) begin
      o_frame_start <= 1'b1;
      o_frame_seconds <= seconds_reg[6:0];
      o_frame_minutes <= minutes_reg[6:0];
      o_frame_hours <= hours_reg[5:0];
      o_frame_days <= days_reg[9:0];
      o_frame_years <= years_reg[7:0];
      o_frame_control <= control_field_reg[17:0];
      o_frame_straight_binary_seconds_of_day <= binary_seconds_reg[16:0];
      o_frame_leap_insert <= leap_match;
    end else begin
      o_frame_start <= 1'b0;
    end
  end

endmodule // irig_output_time_registers

`default_nettype wire

// ### test/irig_output_time_registers_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module irig_output_time_registers_asserts (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  // Register bus
  input wire logic i_s_axi_awvalid,
  input wire logic o_s_axi_awready,
  input wire logic i_s_axi_wvalid,
  input wire logic o_s_axi_wready,
  input wire logic o_s_axi_bvalid,
  input wire logic [1:0] o_s_axi_bresp,
  input wire logic i_s_axi_arvalid,
  input wire logic o_s_axi_arready,
  input wire logic o_s_axi_rvalid,
  input wire logic [31:0] o_s_axi_rdata,
  input wire logic i_s_axi_rready,
  // Frame outputs
  input wire logic o_frame_start,
  input wire logic [6:0] o_frame_seconds,
  input wire logic [17:0] o_frame_control,
  input wire logic [16:0] o_frame_straight_binary_seconds_of_day,
  input wire logic o_frame_leap_insert
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  ////////////////////////////////////////////////////////////////
  // Frame fields may only move at a frame marker or a toggle write
  a_start_pulse: assert property (o_frame_start |=> !o_frame_start)
    else $error("frame marker longer than one cycle");
  a_sec_load: assert property ($changed(o_frame_seconds) |-> o_frame_start || $rose(o_s_axi_bvalid))
    else $error("seconds field moved outside a frame load");
  a_ctrl_load: assert property ($changed(o_frame_control) |-> o_frame_start || $rose(o_s_axi_bvalid))
    else $error("control field moved outside a frame load");
  a_bin_load: assert property ($changed(o_frame_straight_binary_seconds_of_day) |->
    o_frame_start || $rose(o_s_axi_bvalid)) else $error("binary seconds moved outside a frame load");
  a_leap_load: assert property ($changed(o_frame_leap_insert) |-> o_frame_start || $rose(o_s_axi_bvalid))
    else $error("leap flag moved outside a frame load");
  // Register access answers, so fields are reachable by software
  a_read_answer: assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid)
    else $error("read not answered next cycle");
  a_read_stands: assert property (o_s_axi_rvalid && !i_s_axi_rready |=>
    o_s_axi_rvalid && $stable(o_s_axi_rdata)) else $error("read data dropped before taken");
  a_write_answer: assert property (i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid &&
    o_s_axi_wready |=> !o_s_axi_awready ##1 o_s_axi_bvalid && !o_s_axi_awready)
    else $error("write not answered");
  c_frame: cover property (o_frame_start);
  c_leap: cover property (o_frame_start ##1 o_frame_leap_insert);
  c_slverr: cover property (o_s_axi_bvalid && o_s_axi_bresp == 2'h2);
endmodule // irig_output_time_registers_asserts
bind irig_output_time_registers irig_output_time_registers_asserts u_asserts (
  .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_s_axi_awvalid(i_s_axi_awvalid),
  .o_s_axi_awready(o_s_axi_awready), .i_s_axi_wvalid(i_s_axi_wvalid),
  .o_s_axi_wready(o_s_axi_wready), .o_s_axi_bvalid(o_s_axi_bvalid),
  .o_s_axi_bresp(o_s_axi_bresp), .i_s_axi_arvalid(i_s_axi_arvalid),
  .o_s_axi_arready(o_s_axi_arready), .o_s_axi_rvalid(o_s_axi_rvalid),
  .o_s_axi_rdata(o_s_axi_rdata), .i_s_axi_rready(i_s_axi_rready),
  .o_frame_start(o_frame_start), .o_frame_seconds(o_frame_seconds),
  .o_frame_control(o_frame_control),
  .o_frame_straight_binary_seconds_of_day(o_frame_straight_binary_seconds_of_day),
  .o_frame_leap_insert(o_frame_leap_insert));
`default_nettype wire

// ### test/irig_frame_receiver.sv
`timescale 1ns/100ps
`default_nettype none
module irig_frame_receiver (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  // Frame as handed to the line encoder
  input wire logic i_start,
  input wire logic [37:0] i_time,
  input wire logic [17:0] i_control,
  input wire logic [16:0] i_binary_secs,
  input wire logic i_leap,
  // Decoded frame
  output var logic [15:0] o_rx_count,
  output var logic [37:0] o_rx_time,
  output var logic [17:0] o_rx_control,
  output var logic [16:0] o_rx_binary_secs,
  output var logic o_rx_leap
);
  // Decode one cycle after the marker, once fields have settled
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rx_count <= 16'h0000;
      o_rx_time <= 38'h0;
      o_rx_control <= 18'h0;
      o_rx_binary_secs <= 17'h0;
      o_rx_leap <= 1'b0;
    end else if (i_start) begin
      o_rx_count <= o_rx_count + 16'h0001;
      o_rx_time <= i_time;
      o_rx_control <= i_control;
      o_rx_binary_secs <= i_binary_secs;
      o_rx_leap <= i_leap;
    end
  end
endmodule // irig_frame_receiver
`default_nettype wire

// ### test/irig_output_time_registers_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "irig_out_defines.vh"
module irig_output_time_registers_tb;
  localparam int P = 64;
  localparam logic [1:0] OK = `RESP_OKAY;
  // Register table: address, writable bits, frame test value
  localparam logic [15:0] ADR [9] = '{`ADDR_DELAY_ADJUST, `ADDR_LEAP_TIME, `ADDR_SECONDS,
    `ADDR_MINUTES, `ADDR_HOURS, `ADDR_DAYS, `ADDR_YEARS, `ADDR_CONTROL_FIELD, `ADDR_BINARY_SECONDS};
  localparam logic [31:0] MSK [9] = '{`MASK_DELAY_ADJUST, `MASK_LEAP_TIME, `MASK_SECONDS,
    `MASK_MINUTES, `MASK_HOURS, `MASK_DAYS, `MASK_YEARS, `MASK_CONTROL_FIELD, `MASK_BINARY_SECONDS};
  localparam logic [31:0] VAL [9] = '{32'h0, 32'h2501_6D17, 32'h3B, 32'h2A, 32'h17, 32'h16D,
    32'h25, 32'h2_A5A5, 32'h1_517F};
  logic i_sys_clk = 1'b0, i_nrst = 1'b0;
  logic [15:0] i_s_axi_awaddr = 16'h0, i_s_axi_araddr = 16'h0;
  logic [31:0] i_s_axi_wdata = 32'h0;
  logic [3:0] i_s_axi_wstrb = 4'h0;
  logic i_s_axi_awvalid = 1'b0, i_s_axi_wvalid = 1'b0, i_s_axi_bready = 1'b0;
  logic i_s_axi_arvalid = 1'b0, i_s_axi_rready = 1'b0;
  wire o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
  wire o_frame_start, o_frame_leap_insert, rx_leap;
  wire [1:0] o_s_axi_bresp, o_s_axi_rresp;
  wire [31:0] o_s_axi_rdata;
  wire [6:0] o_frame_seconds, o_frame_minutes;
  wire [5:0] o_frame_hours;
  wire [9:0] o_frame_days;
  wire [7:0] o_frame_years;
  wire [17:0] o_frame_control, rx_control;
  wire [16:0] o_frame_straight_binary_seconds_of_day, rx_binary_secs;
  wire [15:0] rx_count;
  wire [37:0] rx_time;
  int cyc = 0, err_total = 0, check_count = 0, t0, t1, t2;
  logic [15:0] snap;

  irig_output_time_registers #(.P_FRAME_CYCLES(P)) dut (.*);
  irig_frame_receiver partner (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_start(o_frame_start),
    .i_time({o_frame_years, o_frame_days, o_frame_hours, o_frame_minutes, o_frame_seconds}),
    .i_control(o_frame_control), .i_binary_secs(o_frame_straight_binary_seconds_of_day),
    .i_leap(o_frame_leap_insert), .o_rx_count(rx_count), .o_rx_time(rx_time),
    .o_rx_control(rx_control), .o_rx_binary_secs(rx_binary_secs), .o_rx_leap(rx_leap));

  ////////////////////////////////////////////////////////////////
  // 200 MHz clock and hang guard
  initial begin
    forever #2.5 i_sys_clk = ~i_sys_clk;
  end
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      print_verdict();
    end
  end

  task print_verdict();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %0h seen %0h", n, exp, seen);
    end
  endtask

  ////////////////////////////////////////////////////////////////
  // Bus tasks: ready is sampled at the falling edge, stable up to the next rising one
  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    logic ha, hw, da, dw;
    logic [1:0] r;
    @(posedge i_sys_clk);
    i_s_axi_awaddr <= a;
    i_s_axi_wdata <= d;
    i_s_axi_wstrb <= s;
    i_s_axi_awvalid <= 1'b1;
    i_s_axi_wvalid <= 1'b1;
    i_s_axi_bready <= 1'b1;
    da = 1'b0;
    dw = 1'b0;
    while (!(da && dw)) begin
      @(negedge i_sys_clk);
      ha = i_s_axi_awvalid && o_s_axi_awready;
      hw = i_s_axi_wvalid && o_s_axi_wready;
      @(posedge i_sys_clk);
      if (ha) begin
        i_s_axi_awvalid <= 1'b0;
        da = 1'b1;
      end
      if (hw) begin
        i_s_axi_wvalid <= 1'b0;
        dw = 1'b1;
      end
    end
    do begin
      @(negedge i_sys_clk);
      ha = o_s_axi_bvalid;
      r = o_s_axi_bresp;
      @(posedge i_sys_clk);
    end while (!ha);
    i_s_axi_bready <= 1'b0;
    chk($sformatf("bresp %h", a), r, er);
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] exp, input logic [1:0] er);
    logic h;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge i_sys_clk);
    i_s_axi_araddr <= a;
    i_s_axi_arvalid <= 1'b1;
    i_s_axi_rready <= 1'b1;
    do begin
      @(negedge i_sys_clk);
      h = o_s_axi_arready;
      @(posedge i_sys_clk);
    end while (!h);
    i_s_axi_arvalid <= 1'b0;
    do begin
      @(negedge i_sys_clk);
      h = o_s_axi_rvalid;
      d = o_s_axi_rdata;
      r = o_s_axi_rresp;
      @(posedge i_sys_clk);
    end while (!h);
    i_s_axi_rready <= 1'b0;
    chk($sformatf("read %h", a), {r, d}, {er, exp});
  endtask

  // Returns the cycle at which the receiver decoded the next frame
  task automatic wait_frame(output int t);
    logic [15:0] old;
    @(negedge i_sys_clk);
    old = rx_count;
    while (rx_count === old) @(negedge i_sys_clk);
    t = cyc;
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge i_sys_clk);
    i_nrst <= 1'b1;
    foreach (ADR[k]) rd(ADR[k], 32'h0, OK);
    foreach (ADR[k]) wr(ADR[k], 32'hFFFF_FFFF, 4'hF, OK);
    foreach (ADR[k]) rd(ADR[k], MSK[k], OK);
    wr(`ADDR_CONTROL_FIELD, 32'h0, 4'h1, OK);
    rd(`ADDR_CONTROL_FIELD, 32'h3_FF00, OK);
    wr(16'h6070, 32'h1, 4'hF, `RESP_SLVERR);
    rd(16'h6070, 32'h0, `RESP_SLVERR);
    // Enable, then load frame values before the first marker
    wr(`ADDR_OUT_ENABLE, 32'h1, 4'hF, OK);
    foreach (ADR[k]) wr(ADR[k], VAL[k], 4'hF, OK);
    wait_frame(t0);
    wait_frame(t0);
    chk("rx time", rx_time, {8'h25, 10'h16D, 6'h17, 7'h2A, 7'h3B});
    chk("rx control", rx_control, 18'h2_A5A5);
    chk("rx binary", rx_binary_secs, 17'h1_517F);
    chk("rx leap", rx_leap, 1'b1);
    // Adjust of 10 cycles pulls the next marker earlier by 10, then period resumes
    wr(`ADDR_LEAP_TIME, 32'h2501_6D16, 4'hF, OK);
    // Software side: the wanted offset is already turned into clock cycles here
    wr(`ADDR_DELAY_ADJUST, 32'hA, 4'hF, OK);
    wait_frame(t1);
    wait_frame(t2);
    chk("shifted gap", t1 - t0, P - 10);
    chk("steady gap", t2 - t1, P);
    chk("rx leap off", rx_leap, 1'b0);
    // Toggle off clears everything; an unchanged enable write clears nothing
    wr(`ADDR_OUT_ENABLE, 32'h0, 4'hF, OK);
    chk("frame seconds", o_frame_seconds, 7'h0);
    chk("frame control", o_frame_control, 18'h0);
    foreach (ADR[k]) rd(ADR[k], 32'h0, OK);
    wr(`ADDR_SECONDS, 32'h5, 4'hF, OK);
    wr(`ADDR_OUT_ENABLE, 32'h0, 4'hF, OK);
    rd(`ADDR_SECONDS, 32'h5, OK);
    snap = rx_count;
    repeat (2 * P) @(posedge i_sys_clk);
    chk("frames while off", rx_count, snap);
    print_verdict();
  end
endmodule // irig_output_time_registers_tb
`default_nettype wire
